// >>> rtl/ict_core.sv
`timescale 1ns/1ps

// Notes on behaviour
// - every instruction cycle lasts exactly four system clocks
// - ordinary ops take one cycle; branch, call, table read take two
// - writing program_counter_low_byte jumps and costs one extra cycle
// - a skip takes one cycle unless it skips, then one more
// - conditional tests check a byte or one bit, then go on or skip
// - logical operations set zero flag when result is zero
// - rotates shift one bit; through-carry forms move out bit to carry
// - bit set/clear rewrites only the chosen bit of the byte
// - return resumes after the call; plain branch saves no return
// - add carries above 255; subtract borrows below zero via carry
// - increment and subtract_one change operand by exactly one
module ict_core
   import ict_pkg::*;
#(
   parameter int unsigned PC_W        = 12,
   parameter int unsigned STACK_DEPTH = 8
) (
   input  wire logic            ref_clk,
   input  wire logic            sys_rst,
   input  wire ict_instr_t      instr,
   output logic                 fetch_req,
   output logic [PC_W-1:0]      pc,
   output logic [1:0]           phase,
   output logic                 exec_stb,
   output logic                 flush,
   output ict_result_t          result,
   output logic                 busy
);

   // ---------------------------------------------------------------
   // sequencer state
   // ---------------------------------------------------------------
   // run executes on the last phase of each cycle; dummy is the second,
   // discarded cycle of a two-cycle instruction
   typedef enum logic [1:0] {
      ICT_RUN   = 2'b00,
      ICT_DUMMY = 2'b01
   } ict_state_t;

   // stack pointer width, and the phase on which every cycle ends
   localparam int unsigned SP_W = $clog2(STACK_DEPTH);
   localparam logic [1:0] LAST_PH = 2'(CLKS_PER_CYCLE - 1);

   // sequencer, datapath and write-back registers
   ict_state_t            state_q, state_d;
   logic [1:0]            phase_q, phase_d;
   logic [PC_W-1:0]       pc_q, pc_d;
   logic [PC_W-1:0]       stack_q [STACK_DEPTH];
   logic [PC_W-1:0]       push_val;
   logic                  push, pop;
   logic [SP_W-1:0]       sp_q, sp_d;
   logic [7:0]            acc_q, acc_d;
   logic                  z_q, z_d, c_q, c_d;
   logic                  stb_q, stb_d, fl_q, fl_d, fr_q, fr_d;
   logic [7:0]            mem_q, mem_d;
   logic                  we_q, we_d;
   logic                  busy_q, busy_d;
   logic [PC_W-1:0]       stack_d [STACK_DEPTH];

   // bit mask for the single-bit operations and tests
   function automatic logic [7:0] bit_mask(input logic [2:0] sel);
      bit_mask = 8'h01 << sel;
   endfunction : bit_mask

   // ---------------------------------------------------------------
   // datapath: one result per instruction
   // ---------------------------------------------------------------
   logic [8:0]  sum;
   logic [7:0]  res;
   logic        res_c, upd_z, upd_c, is_skip, skip_hit, two_cycle;
   logic [7:0]  opnd;

   // the operand arrives already read from data memory, so a bit set
   // or clear is a plain mask here and the other seven bits ride through
   // untouched; skips compute no result and write nothing
   always_comb begin
      opnd   = instr.operand;
      sum    = 9'h000;
      res    = acc_q;
      res_c  = c_q;
      upd_z  = 1'b0;
      upd_c  = 1'b0;
      is_skip  = 1'b0;
      skip_hit = 1'b0;
      unique case (instr.op)
         ICT_MOV: res = opnd;
         // nine-bit sums keep the carry or borrow in the top bit
         ICT_ADD, ICT_ADC: begin
            sum   = {1'b0, acc_q} + {1'b0, opnd}
                  + {8'h00, (instr.op == ICT_ADC) & c_q};
            res   = sum[7:0];
            res_c = sum[8];
            upd_z = 1'b1;
            upd_c = 1'b1;
         end
         ICT_SUB, ICT_SBC: begin
            // carry set means no borrow, so carry clear flags below zero
            sum   = {1'b0, acc_q} - {1'b0, opnd}
                  - {8'h00, (instr.op == ICT_SBC) & ~c_q};
            res   = sum[7:0];
            res_c = ~sum[8];
            upd_z = 1'b1;
            upd_c = 1'b1;
         end
         ICT_AND: begin res = acc_q & opnd; upd_z = 1'b1; end
         ICT_OR:  begin res = acc_q | opnd; upd_z = 1'b1; end
         ICT_XOR: begin res = acc_q ^ opnd; upd_z = 1'b1; end
         ICT_CPL: begin res = ~opnd;        upd_z = 1'b1; end
         ICT_INC: begin
            res   = opnd + ONE_BYTE;
            upd_z = 1'b1;
         end
         ICT_SUB_ONE: begin
            res   = opnd - ONE_BYTE;
            upd_z = 1'b1;
         end
         ICT_RR: res = {opnd[0], opnd[7:1]};
         ICT_RL: res = {opnd[6:0], opnd[7]};
         // through-carry forms feed the old carry in, catch the bit out
         ICT_RR_CARRY: begin
            res   = {c_q, opnd[7:1]};
            res_c = opnd[0];
            upd_c = 1'b1;
         end
         ICT_RL_CARRY: begin
            res   = {opnd[6:0], c_q};
            res_c = opnd[7];
            upd_c = 1'b1;
         end
         ICT_BIT_SET: res = opnd |  bit_mask(instr.bit_sel);
         ICT_BIT_CLR: res = opnd & ~bit_mask(instr.bit_sel);
         // skip tests only decide; the result stays the accumulator
         ICT_SKIP_Z:   begin is_skip = 1'b1; skip_hit = opnd == 8'h00; end
         ICT_SKIP_NZ:  begin is_skip = 1'b1; skip_hit = opnd != 8'h00; end
         ICT_SKIP_BZ:  begin
            is_skip  = 1'b1;
            skip_hit = (opnd & bit_mask(instr.bit_sel)) == 8'h00;
         end
         ICT_SKIP_BNZ: begin
            is_skip  = 1'b1;
            skip_hit = (opnd & bit_mask(instr.bit_sel)) != 8'h00;
         end
         default: res = acc_q;
      endcase
      // an extra cycle for control transfers, table reads, pcl writes;
      // only a result bound for data memory can land in the low pc byte,
      // so dst_pcl with an accumulator destination never costs the dummy cycle
      two_cycle = (instr.op inside {ICT_BRANCH, ICT_CALL, ICT_BACK,
                                    ICT_BACK_INT, ICT_TABLE_RD})
                | (instr.dst_pcl & instr.to_mem & ~is_skip)
                | skip_hit;
   end

   // ---------------------------------------------------------------
   // sequencer: phase counter, program counter, return stack
   // ---------------------------------------------------------------
   // instr is looked at only on the last phase of a run cycle; the
   // phase counter keeps turning through the dummy cycle as well, so
   // every cycle, dummy or not, spans exactly four clocks
   always_comb begin
      // defaults: hold all state, step the phase, no strobes
      state_d  = state_q;
      phase_d  = phase_q + 2'h1;
      pc_d     = pc_q;
      sp_d     = sp_q;
      push     = 1'b0;
      pop      = 1'b0;
      push_val = pc_q + PC_W'(1);
      acc_d    = acc_q;
      z_d      = z_q;
      c_d      = c_q;
      mem_d    = mem_q;
      we_d     = 1'b0;
      stb_d    = 1'b0;
      fl_d     = 1'b0;
      fr_d     = 1'b0;
      if (phase_q == LAST_PH) begin
         phase_d = 2'h0;
         fr_d    = 1'b1;
         unique case (state_q)
            ICT_RUN: begin
               stb_d = 1'b1;
               pc_d  = pc_q + PC_W'(1);
               if (upd_z) z_d = (res == 8'h00);
               if (upd_c) c_d = res_c;
               // write-back: memory gets a one-clock strobe, the
               // accumulator just takes the value; a skip leaves both
               if (instr.to_mem) begin
                  mem_d = res;
                  we_d  = ~is_skip;
               end else if (!is_skip) begin
                  acc_d = res;
               end
               // next pc; control transfers replace the plain step
               unique case (instr.op)
                  ICT_BRANCH: pc_d = instr.target;
                  ICT_CALL: begin
                     pc_d = instr.target;
                     push = 1'b1;
                  end
                  ICT_BACK, ICT_BACK_INT: begin
                     pc_d = stack_q[sp_q - SP_W'(1)];
                     pop  = 1'b1;
                  end
                  ICT_SKIP_Z, ICT_SKIP_NZ, ICT_SKIP_BZ, ICT_SKIP_BNZ:
                     if (skip_hit) pc_d = pc_q + PC_W'(2);
                  // a memory write aimed at the low pc byte keeps the page
                  default:
                     if (instr.dst_pcl && instr.to_mem)
                        pc_d = {pc_q[PC_W-1:8], res};
               endcase
               // the word fetched behind a two-cycle op is stale: drop it
               // and spend a dummy cycle refetching from the new pc
               if (two_cycle) begin
                  state_d = ICT_DUMMY;
                  fl_d    = 1'b1;
               end
            end
            ICT_DUMMY: state_d = ICT_RUN;
            default:   state_d = ICT_RUN;
         endcase
      end
      // the pointer moves only with a push or a pop; nothing guards
      // overflow, so a call past the stack depth overwrites an entry
      if (push) begin
         sp_d = sp_q + SP_W'(1);
      end else if (pop) begin
         sp_d = sp_q - SP_W'(1);
      end
      // busy is registered so the port comes straight from a flip-flop
      busy_d = (state_d == ICT_DUMMY);
   end

   // register all sequencer state
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_q <= ICT_RUN;
         phase_q <= 2'h0;
         pc_q    <= '0;
         sp_q    <= '0;
         acc_q   <= 8'h00;
         z_q     <= 1'b0;
         c_q     <= 1'b0;
         mem_q   <= 8'h00;
         we_q    <= 1'b0;
         stb_q   <= 1'b0;
         fl_q    <= 1'b0;
         fr_q    <= 1'b0;
         busy_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         phase_q <= phase_d;
         pc_q    <= pc_d;
         sp_q    <= sp_d;
         acc_q   <= acc_d;
         z_q     <= z_d;
         c_q     <= c_d;
         mem_q   <= mem_d;
         we_q    <= we_d;
         stb_q   <= stb_d;
         fl_q    <= fl_d;
         fr_q    <= fr_d;
         busy_q  <= busy_d;
      end
   end

   // ---------------------------------------------------------------
   // return stack
   // ---------------------------------------------------------------
   // the return point is the word after the call; no reset, since a
   // pop before any push is a program fault anyway
   always_comb begin
      stack_d = stack_q;
      if (push) begin
         stack_d[sp_q] = push_val;
      end
   end

   // the stack only registers its next contents
   always_ff @(posedge ref_clk) begin
      stack_q <= stack_d;
   end

   // ---------------------------------------------------------------
   // outputs, all from flip-flops
   // ---------------------------------------------------------------
   // every port is a register; nothing combinational reaches a pin
   assign pc              = pc_q;
   assign phase           = phase_q;
   assign exec_stb        = stb_q;
   assign flush           = fl_q;
   assign fetch_req       = fr_q;
   assign busy            = busy_q;
   assign result.acc      = acc_q;
   assign result.mem_data = mem_q;
   assign result.mem_we   = we_q;
   assign result.zero     = z_q;
   assign result.carry    = c_q;

endmodule : ict_core

// >>> rtl/ict_pkg.sv
package ict_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLKS_PER_CYCLE = 4;
   localparam logic [7:0]  BYTE_MAX       = 8'hff;
   localparam logic [7:0]  ONE_BYTE       = 8'h01;

   // ---------------------------------------------------------------
   // operation classes presented by the decoder in front of this block
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      ICT_NOP      = 5'h00,
      ICT_MOV      = 5'h01,
      ICT_ADD      = 5'h02,
      ICT_ADC      = 5'h03,
      ICT_SUB      = 5'h04,
      ICT_SBC      = 5'h05,
      ICT_AND      = 5'h06,
      ICT_OR       = 5'h07,
      ICT_XOR      = 5'h08,
      ICT_CPL      = 5'h09,
      ICT_INC      = 5'h0a,
      ICT_SUB_ONE  = 5'h0b,
      ICT_RR       = 5'h0c,
      ICT_RL       = 5'h0d,
      ICT_RR_CARRY = 5'h0e,
      ICT_RL_CARRY = 5'h0f,
      ICT_BIT_SET  = 5'h10,
      ICT_BIT_CLR  = 5'h11,
      ICT_SKIP_Z   = 5'h12,
      ICT_SKIP_NZ  = 5'h13,
      ICT_SKIP_BZ  = 5'h14,
      ICT_SKIP_BNZ = 5'h15,
      ICT_BRANCH   = 5'h16,
      ICT_CALL     = 5'h17,
      ICT_BACK     = 5'h18,
      ICT_BACK_INT = 5'h19,
      ICT_TABLE_RD = 5'h1a
   } ict_op_t;

   // one decoded instruction
   typedef struct packed {
      ict_op_t     op;
      logic        to_mem;     // result to data memory, else accumulator
      logic        imm;        // operand is immediate, not memory
      logic        dst_pcl;    // destination is program_counter_low_byte
      logic [2:0]  bit_sel;
      logic [7:0]  operand;    // immediate or memory data
      logic [11:0] target;     // branch / call address
   } ict_instr_t;

   // result of one executed instruction
   typedef struct packed {
      logic [7:0]  acc;
      logic [7:0]  mem_data;
      logic        mem_we;
      logic        zero;
      logic        carry;
   } ict_result_t;

endpackage : ict_pkg

// >>> dv/ict_core_asserts.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port checks for the instruction cycle core
// ---------------------------------------------------------------
module ict_core_asserts
   import ict_pkg::*;
#(
   parameter int unsigned PC_W = 12
) (
   input wire logic            ref_clk,
   input wire logic            sys_rst,
   input wire ict_instr_t      instr,
   input wire logic            fetch_req,
   input wire logic [PC_W-1:0] pc,
   input wire logic [1:0]      phase,
   input wire logic            exec_stb,
   input wire logic            flush,
   input wire ict_result_t     result,
   input wire logic            busy
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   // four phases per cycle, no phase ever skipped
   phase_step_a: assert property (
      1'b1 |=> phase == 2'($past(phase) + 2'h1))
      else $error("phase did not advance by one");
   exec_place_a: assert property (
      exec_stb |-> phase == 2'h0 && $past(phase) == 2'h3 && !$past(busy))
      else $error("execution outside the last phase");
   exec_take_a: assert property (
      phase == 2'h3 && !busy |=> exec_stb)
      else $error("instruction not executed");
   busy_len_a: assert property (
      $rose(busy) |-> busy [*4] ##1 !busy)
      else $error("dummy cycle not four clocks");
   // the discarded prefetch and the dummy cycle always come together
   flush_pair_a: assert property (
      flush || $rose(busy) |-> exec_stb && flush && busy)
      else $error("flush and dummy cycle apart");
   hold_off_a: assert property (
      $past(busy) |-> !exec_stb)
      else $error("executed during dummy cycle");
   // a reset edge also drops busy, so that fall is not a refetch
   refetch_a: assert property (
      $fell(busy) && !$past(sys_rst) |-> fetch_req && !exec_stb)
      else $error("no refetch after dummy cycle");
   pc_step_a: assert property (
      exec_stb && !busy |-> pc == $past(pc) + 1'b1)
      else $error("one-cycle op did not step pc");
   mem_we_a: assert property (
      result.mem_we |-> exec_stb)
      else $error("write-back without execution");
   zero_flag_a: assert property (
      exec_stb && !$past(instr.to_mem) &&
      $past(instr.op) inside {ICT_AND, ICT_OR, ICT_XOR}
      |-> result.zero == (result.acc == 8'h00))
      else $error("zero flag wrong after logic op");
endmodule : ict_core_asserts

// >>> dv/testbench.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// self-checking bench for the instruction cycle core
// ---------------------------------------------------------------
module testbench;
   import ict_pkg::*;
   logic        ref_clk;
   logic        sys_rst;
   ict_instr_t  instr;
   logic        fetch_req;
   logic [11:0] pc;
   logic [1:0]  phase;
   logic        exec_stb;
   logic        flush;
   ict_result_t result;
   logic        busy;
   logic [2:0]  bsel;
   logic [11:0] pc0;
   int          n_fail;
   int          n_checks;
   int          cyc = 0;

   ict_core #(.PC_W(12), .STACK_DEPTH(8)) DUT (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .instr(instr),
      .fetch_req(fetch_req), .pc(pc), .phase(phase),
      .exec_stb(exec_stb), .flush(flush), .result(result), .busy(busy));

   // clock and a hang limit far above the few hundred cycles needed
   initial ref_clk = 1'b0;
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         final_report();
      end
   end

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // present one op; fl is {two-cycle, to memory, pcl destination}
   task automatic run(input ict_op_t op, input logic [2:0] fl,
      input logic [7:0] opd, input logic [11:0] tgt);
      int n;
      @(negedge ref_clk);
      pc0 = pc;
      instr = '{op, fl[1], 1'h0, fl[0], bsel, opd, tgt};
      n = 0;
      do begin
         @(posedge ref_clk);
         #1 n++;
      end while (exec_stb !== 1'b1 && n < 16);
      chk(exec_stb, 1'h1);
      chk(busy, fl[2]);
      chk(flush, fl[2]);
      chk(fetch_req, 1'h1);
      // idle op held afterwards so nothing executes twice
      @(negedge ref_clk);
      instr.op = ICT_NOP;
      n = 0;
      while (busy === 1'b1 && n < 9) begin
         @(posedge ref_clk);
         #1 n++;
      end
      if (fl[2]) chk(16'(n), 16'h0004);
   endtask : run

   task automatic t_arith;
      run(ICT_MOV, 3'h0, 8'hf0, 12'h000);
      run(ICT_ADD, 3'h0, 8'h10, 12'h000);
      chk({result.acc, result.carry, result.zero}, 10'h003);
      run(ICT_SUB, 3'h0, 8'h01, 12'h000);
      chk({result.acc, result.carry, result.zero}, 10'h3fc);
      chk(pc, pc0 + 12'h001);
      run(ICT_ADC, 3'h0, 8'h01, 12'h000);
      chk({result.acc, result.carry, result.zero}, 10'h003);
      run(ICT_ADC, 3'h0, 8'h01, 12'h000);
      chk({result.acc, result.carry, result.zero}, 10'h008);
      run(ICT_SBC, 3'h0, 8'h01, 12'h000);
      chk({result.acc, result.carry, result.zero}, 10'h003);
      $display("arith test done");
   endtask : t_arith

   task automatic t_logic;
      ict_op_t    ops [3] = '{ICT_AND, ICT_OR, ICT_XOR};
      logic [7:0] res [3] = '{8'h00, 8'h0f, 8'h00};
      run(ICT_MOV, 3'h0, 8'hf0, 12'h000);
      foreach (ops[i]) begin
         run(ops[i], 3'h0, 8'h0f, 12'h000);
         chk({result.acc, result.zero}, {res[i], res[i] == 8'h00});
      end
      run(ICT_CPL, 3'h0, 8'hff, 12'h000);
      chk({result.acc, result.zero}, 9'h001);
      $display("logic test done");
   endtask : t_logic

   task automatic t_step;
      run(ICT_INC, 3'h0, 8'hff, 12'h000);
      chk({result.acc, result.zero}, 9'h001);
      run(ICT_SUB_ONE, 3'h2, 8'h00, 12'h000);
      chk({result.mem_data, result.mem_we, result.zero}, 10'h3fe);
      run(ICT_RR, 3'h0, 8'h01, 12'h000);
      chk(result.acc, 8'h80);
      run(ICT_RL, 3'h0, 8'h80, 12'h000);
      chk(result.acc, 8'h01);
      run(ICT_RR_CARRY, 3'h0, 8'h01, 12'h000);
      chk({result.acc, result.carry}, 9'h101);
      run(ICT_RL_CARRY, 3'h0, 8'h00, 12'h000);
      chk({result.acc, result.carry}, 9'h002);
      bsel = 3'h3;
      run(ICT_BIT_SET, 3'h2, 8'ha5, 12'h000);
      chk({result.mem_data, result.mem_we}, 9'h15b);
      bsel = 3'h7;
      run(ICT_BIT_CLR, 3'h2, 8'ha5, 12'h000);
      chk({result.mem_data, result.mem_we}, 9'h04b);
      $display("step, rotate and bit test done");
   endtask : t_step

   // each skip form with a zero and a non-zero operand, aimed at data
   // memory so that a stray write-back would show
   task automatic t_skip;
      ict_op_t ops [4] = '{ICT_SKIP_Z, ICT_SKIP_NZ, ICT_SKIP_BZ,
                           ICT_SKIP_BNZ};
      logic    tk;
      bsel = 3'h0;
      for (int i = 0; i < 8; i++) begin
         tk = (i[0] == 1'b0) ^ i[1];
         run(ops[i >> 1], {tk, 2'h2}, {7'h00, i[0]}, 12'h000);
         chk(pc, pc0 + (tk ? 12'h002 : 12'h001));
         chk(result.mem_we, 1'h0);
      end
      $display("skip test done");
   endtask : t_skip

   task automatic t_flow;
      run(ICT_BRANCH, 3'h4, 8'h00, 12'h123);
      chk(pc, 12'h123);
      run(ICT_CALL, 3'h4, 8'h00, 12'h200);
      chk(pc, 12'h200);
      run(ICT_BRANCH, 3'h4, 8'h00, 12'h050);
      run(ICT_BACK, 3'h4, 8'h00, 12'h000);
      chk(pc, 12'h124);
      run(ICT_TABLE_RD, 3'h4, 8'h00, 12'h000);
      run(ICT_INC, 3'h7, 8'h43, 12'h000);
      chk(pc, {pc0[11:8], 8'h44});
      run(ICT_CALL, 3'h4, 8'h00, 12'h300);
      run(ICT_BACK_INT, 3'h4, 8'h00, 12'h000);
      chk(pc, 12'h145);
      $display("flow test done");
   endtask : t_flow

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report

   initial begin
      n_fail = 0;
      n_checks = 0;
      bsel = 3'h0;
      instr = '0;
      sys_rst = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk({pc, phase, busy, result.acc}, 23'h0);
      sys_rst = 1'b0;
      t_arith();
      t_logic();
      t_step();
      t_skip();
      t_flow();
      final_report();
   end
endmodule : testbench

bind ict_core ict_core_asserts #(.PC_W(PC_W)) u_chk (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .instr(instr),
   .fetch_req(fetch_req), .pc(pc), .phase(phase),
   .exec_stb(exec_stb), .flush(flush), .result(result), .busy(busy));
